//--- design/betu_pkg.sv
// Shared constants and types for the bus event, trace and timing unit.
package betu_pkg;
	localparam int NUM_CH = 12;
	localparam int AW     = 32;
	localparam int DW     = 32;
	localparam int IRQW   = 8;
	localparam int TS_W   = 32;
	localparam int MC_W   = 24;
	localparam int EC_W   = 16;
	localparam int PTR_W  = 16;

	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	localparam logic TRC_STAMP = 1'b0;
	localparam logic TRC_IRQ   = 1'b1;

	localparam logic [1:0] RES_20NS  = 2'h0;
	localparam logic [1:0] RES_1U6   = 2'h1;
	localparam logic [1:0] RES_52US  = 2'h2;
	localparam logic [1:0] RES_CLOCK = 2'h3;

	localparam int CLK_PS      = 25000;
	localparam int RES_20NS_PS = 20000;
	localparam int RES_1U6_PS  = 1600000;
	localparam int RES_52US_PS = 52000000;
	localparam int RES_20NS_CYC = (RES_20NS_PS / CLK_PS < 1) ? 1 : RES_20NS_PS / CLK_PS;
	localparam int RES_1U6_CYC  = (RES_1U6_PS / CLK_PS < 1) ? 1 : RES_1U6_PS / CLK_PS;
	localparam int RES_52US_CYC = (RES_52US_PS / CLK_PS < 1) ? 1 : RES_52US_PS / CLK_PS;
	localparam int RES_CNT_W    = 12;

	localparam int BRK_DELAY_CYC  = 3;
	localparam int TRACE_TAIL_BUS = 4;
	localparam int SETTLE_BUS     = 6;
	localparam int PROF_CH_LO     = 8;
	localparam int PROF_CH_HI     = 11;
	localparam logic [EC_W-1:0] EVT_MAX = 16'hFFFF;
	localparam logic [MC_W-1:0] MC_MAX  = 24'hFFFFFF;

	typedef enum logic [2:0] {
		MM_P2P   = 3'h0,
		MM_RANGE = 3'h1,
		MM_R2R   = 3'h2,
		MM_ACC   = 3'h3,
		MM_CALL  = 3'h4
	} betu_mode_e;

	typedef enum logic [2:0] {
		TS_RUN  = 3'b001,
		TS_TAIL = 3'b010,
		TS_STOP = 3'b100
	} betu_trc_e;

	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_RUN  = 3'b010,
		MS_GAP  = 3'b100
	} betu_meas_e;

	typedef enum logic [2:0] {
		OWN_NONE  = 3'b001,
		OWN_TRACE = 3'b010,
		OWN_MEAS  = 3'b100
	} betu_own_e;
endpackage : betu_pkg

//--- design/betu_if.sv
// Interface joining the target bus tap and the emulator event unit.
`timescale 1ns/1ps
interface betu_if;
	import betu_pkg::*;
	// Target bus cycle.
	logic                   cyc;
	logic [AW-1:0]          addr;
	logic [DW-1:0]          data;
	logic [1:0]             size;
	logic                   fetch;
	logic [IRQW-1:0]        irq;
	// Channel conditions.
	logic [NUM_CH-1:0]         ch_en;
	logic [NUM_CH-1:0][AW-1:0] ch_addr;
	logic [NUM_CH-1:0][AW-1:0] ch_amask;
	logic [NUM_CH-1:0]         ch_den;
	logic [NUM_CH-1:0][DW-1:0] ch_data;
	logic [NUM_CH-1:0][DW-1:0] ch_dmask;
	logic [NUM_CH-1:0][1:0]    ch_dsize;

	modport emu (input cyc, addr, data, size, fetch, irq,
		ch_en, ch_addr, ch_amask, ch_den, ch_data, ch_dmask, ch_dsize);
	modport tgt (output cyc, addr, data, size, fetch, irq,
		ch_en, ch_addr, ch_amask, ch_den, ch_data, ch_dmask, ch_dsize);
endinterface : betu_if

//--- design/betu_target_tap.sv
// Target-side end: registers bus cycles and prepares channel conditions.
`timescale 1ns/1ps
module betu_target_tap (
	// Clock and reset.
	input  wire logic                                      clk,
	input  wire logic                                      resetn,
	// Link.
	betu_if.tgt                                            lnk,
	// Target bus cycle.
	input  wire logic                                      cpu_cyc,
	input  wire logic [betu_pkg::AW-1:0]                   cpu_addr,
	input  wire logic [betu_pkg::DW-1:0]                   cpu_data,
	input  wire logic [1:0]                                cpu_size,
	input  wire logic                                      cpu_fetch,
	input  wire logic                                      cpu_run,
	// Interrupt request pins, asynchronous.
	input  wire logic [betu_pkg::IRQW-1:0]                 external_interrupt_request_lines,
	// Channel settings.
	input  wire logic [betu_pkg::NUM_CH-1:0]               cfg_en,
	input  wire logic [betu_pkg::NUM_CH-1:0][betu_pkg::AW-1:0] cfg_addr,
	input  wire logic [betu_pkg::NUM_CH-1:0][betu_pkg::AW-1:0] cfg_amask,
	input  wire logic [betu_pkg::NUM_CH-1:0]               cfg_den,
	input  wire logic [betu_pkg::NUM_CH-1:0][betu_pkg::DW-1:0] cfg_data,
	input  wire logic [betu_pkg::NUM_CH-1:0][betu_pkg::DW-1:0] cfg_dmask,
	input  wire logic [betu_pkg::NUM_CH-1:0][1:0]          cfg_dsize,
	// Run status.
	output logic                                           run_settled
);
	import betu_pkg::*;

	logic [IRQW-1:0] irq_s1_r;
	logic [IRQW-1:0] irq_s2_r;
	logic [2:0]      settle_r;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_s1_r <= '0;
			irq_s2_r <= '0;
		end else begin
			irq_s1_r <= external_interrupt_request_lines;
			irq_s2_r <= irq_s1_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lnk.cyc   <= 1'b0;
			lnk.addr  <= '0;
			lnk.data  <= '0;
			lnk.size  <= SZ_BYTE;
			lnk.fetch <= 1'b0;
			lnk.irq   <= '0;
		end else begin
			lnk.cyc   <= cpu_cyc & cpu_run;
			lnk.addr  <= cpu_addr;
			lnk.data  <= cpu_data;
			lnk.size  <= cpu_size;
			lnk.fetch <= cpu_fetch;
			lnk.irq   <= irq_s2_r;
		end
	end

	// Trace stop conditions are unreliable until six bus cycles have run.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle_r <= '0;
		end else if (!cpu_run) begin
			settle_r <= '0;
		end else if (cpu_cyc && settle_r != 3'(SETTLE_BUS)) begin
			settle_r <= settle_r + 3'h1;
		end
	end
	assign run_settled = (settle_r == 3'(SETTLE_BUS));

	////////////////////////////////////////////////////////////////////////////
	// Lanes are big-endian: the byte at offset zero rides on bits 31:24.
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic [DW-1:0] lane_m;
		always_comb begin
			lane_m = '0;
			if (cfg_dsize[g] == SZ_BYTE) begin
				lane_m = ~(32'hFF000000 >> {cfg_addr[g][1:0], 3'h0});
			end else if (cfg_dsize[g] == SZ_WORD) begin
				lane_m = cfg_addr[g][1] ? 32'hFFFF0000 : 32'h0000FFFF;
			end
		end
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				lnk.ch_en[g]    <= 1'b0;
				lnk.ch_addr[g]  <= '0;
				lnk.ch_amask[g] <= '0;
				lnk.ch_den[g]   <= 1'b0;
				lnk.ch_data[g]  <= '0;
				lnk.ch_dmask[g] <= '0;
				lnk.ch_dsize[g] <= SZ_BYTE;
			end else begin
				lnk.ch_en[g]    <= cfg_en[g];
				lnk.ch_addr[g]  <= cfg_addr[g];
				lnk.ch_amask[g] <= cfg_amask[g];
				lnk.ch_den[g]   <= cfg_den[g];
				lnk.ch_data[g]  <= cfg_data[g];
				lnk.ch_dmask[g] <= cfg_dmask[g] | lane_m;
				lnk.ch_dsize[g] <= cfg_dsize[g];
			end
		end
	end
endmodule : betu_target_tap

//--- design/betu_event_unit.sv
// Emulator-side end: bus event matching, break, trace capture and timing.
`timescale 1ns/1ps
module betu_event_unit (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// Link.
	betu_if.emu                              lnk,
	// Break control.
	input  wire logic                        brk_en,
	input  wire logic                        prof_active,
	output logic                             break_req,
	// Trace control.
	input  wire logic                        trc_arm,
	input  wire logic                        trc_content_sel,
	input  wire logic                        trc_p2p_en,
	input  wire logic [betu_pkg::NUM_CH-1:0] trc_stop_mask,
	output logic                             trc_stopped,
	// Trace records.
	output logic                             rec_valid,
	output logic [betu_pkg::AW-1:0]          rec_addr,
	output logic [betu_pkg::DW-1:0]          rec_data,
	output logic [betu_pkg::TS_W-1:0]        rec_stamp,
	output logic [betu_pkg::IRQW-1:0]        rec_irq,
	output logic [betu_pkg::PTR_W-1:0]       trace_record_pointer,
	// Measurement control.
	input  wire logic                        meas_en,
	input  wire betu_pkg::betu_mode_e        meas_mode,
	input  wire logic [3:0]                  meas_start_ch,
	input  wire logic [3:0]                  meas_end_ch,
	input  wire logic [1:0]                  res_sel,
	input  wire logic                        meas_clear,
	// Measurement results and channel 1 ownership.
	output logic [betu_pkg::MC_W-1:0]        meas_cnt,
	output logic                             meas_ovf,
	output logic                             meas_busy,
	output logic [betu_pkg::EC_W-1:0]        evt_cnt,
	output betu_pkg::betu_own_e              ch1_owner
);
	import betu_pkg::*;

	logic [NUM_CH-1:0]        hit, ahit, brk_hit;
	logic [BRK_DELAY_CYC-1:0] brk_pipe_r;
	logic [TS_W-1:0]          ts_r;
	betu_trc_e                trc_r;
	logic [2:0]               tail_r;
	logic                     win_r;
	betu_own_e                own_r;
	betu_meas_e               ms_r;
	logic [RES_CNT_W-1:0]     pre_r, res_cyc;
	logic                     tick, m_start, m_end, in_rng, in_rng_prev_r, trc_rec, meas_req;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel comparators.
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic [AW-1:0] am;
		logic          a_ok;
		logic          d_ok;
		always_comb begin
			am = lnk.ch_amask[g];
			if (lnk.ch_dsize[g] == SZ_LONG) am[1:0] = 2'h3;
			else if (lnk.ch_dsize[g] == SZ_WORD) am[0] = 1'b1;
		end
		// A byte condition keeps bits 1:0 so odd and even addresses are told apart.
		assign a_ok = ((lnk.addr ^ lnk.ch_addr[g]) & ~am) == '0;
		assign d_ok = !lnk.ch_den[g] || ((lnk.size == lnk.ch_dsize[g]) &&
			(((lnk.data ^ lnk.ch_data[g]) & ~lnk.ch_dmask[g]) == '0));
		assign ahit[g] = lnk.cyc && lnk.ch_en[g] && a_ok;
		assign hit[g]  = ahit[g] && d_ok;
		assign brk_hit[g] = hit[g] && !(prof_active && g >= PROF_CH_LO &&
			g <= PROF_CH_HI);
	end

	////////////////////////////////////////////////////////////////////////////
	// Break is issued late so the core may run slightly past the access.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) brk_pipe_r <= '0;
		else brk_pipe_r <= {brk_pipe_r[BRK_DELAY_CYC-2:0], brk_en && (|brk_hit)};
	end
	assign break_req = brk_pipe_r[BRK_DELAY_CYC-1];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) ts_r <= '0;
		else ts_r <= ts_r + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel 1 ownership; trace wins a same-cycle tie.
	assign meas_req = meas_en && (meas_start_ch == 4'h0 || meas_end_ch == 4'h0);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			own_r <= OWN_NONE;
		end else begin
			case (own_r)
				OWN_NONE: begin
					if (trc_p2p_en) begin
						own_r <= OWN_TRACE;
					end else if (meas_req) begin
						own_r <= OWN_MEAS;
					end
				end
				OWN_TRACE: if (!trc_p2p_en) own_r <= OWN_NONE;
				OWN_MEAS:  if (!meas_req) own_r <= OWN_NONE;
				default: own_r <= OWN_NONE;
			endcase
		end
	end
	assign ch1_owner = own_r;

	////////////////////////////////////////////////////////////////////////////
	// Trace capture. Point-to-point opens on channel 1 and closes on channel 2.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) win_r <= 1'b0;
		else if (trc_arm || own_r != OWN_TRACE) win_r <= 1'b0;
		else if (hit[0]) win_r <= 1'b1;
		else if (hit[1]) win_r <= 1'b0;
	end
	assign trc_rec = lnk.cyc && trc_r != TS_STOP && (!trc_p2p_en ||
		(own_r == OWN_TRACE && (win_r || hit[0])));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trc_r  <= TS_RUN;
			tail_r <= '0;
		end else if (trc_arm) begin
			trc_r  <= TS_RUN;
			tail_r <= '0;
		end else begin
			case (trc_r)
				TS_RUN: begin
					if (|(hit & trc_stop_mask)) begin
						trc_r  <= TS_TAIL;
						tail_r <= 3'(TRACE_TAIL_BUS);
					end
				end
				TS_TAIL: begin
					if (lnk.cyc) begin
						tail_r <= tail_r - 3'h1;
						if (tail_r == 3'h1) trc_r <= TS_STOP;
					end
				end
				TS_STOP: trc_r <= TS_STOP;
				default: trc_r <= TS_STOP;
			endcase
		end
	end
	assign trc_stopped = (trc_r == TS_STOP);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rec_valid            <= 1'b0;
			rec_addr             <= '0;
			rec_data             <= '0;
			rec_stamp            <= '0;
			rec_irq              <= '0;
			trace_record_pointer <= '0;
		end else begin
			rec_valid <= trc_rec && !trc_arm;
			if (trc_arm) trace_record_pointer <= '0;
			else if (trc_rec) begin
				rec_addr             <= lnk.addr;
				rec_data             <= lnk.data;
				trace_record_pointer <= trace_record_pointer + 16'h1;
				if (trc_content_sel == TRC_IRQ) begin
					rec_stamp <= {ts_r[TS_W-1:16], 16'h0000};
					rec_irq   <= lnk.irq;
				end else begin
					rec_stamp <= ts_r;
					rec_irq   <= '0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Resolution prescaler runs freely so a short gap keeps its phase.
	always_comb begin
		case (res_sel)
			RES_20NS: res_cyc = RES_CNT_W'(RES_20NS_CYC);
			RES_1U6:  res_cyc = RES_CNT_W'(RES_1U6_CYC);
			RES_52US: res_cyc = RES_CNT_W'(RES_52US_CYC);
			default:  res_cyc = 12'h001;
		endcase
	end
	assign tick = (pre_r >= res_cyc - 12'h001);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) pre_r <= '0;
		else pre_r <= tick ? '0 : pre_r + 12'h001;
	end

	// Only prefetch addresses start or end a timed interval.
	always_comb begin
		in_rng  = lnk.fetch && ahit[meas_start_ch];
		m_start = in_rng && (meas_start_ch != 4'h0 || own_r == OWN_MEAS);
		m_end   = lnk.fetch && ahit[meas_end_ch] &&
			(meas_end_ch != 4'h0 || own_r == OWN_MEAS);
		if (meas_mode == MM_RANGE) begin
			m_end = lnk.cyc && lnk.fetch && !in_rng;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) ms_r <= MS_IDLE;
		else if (!meas_en || meas_mode == MM_ACC || meas_mode == MM_CALL) ms_r <= MS_IDLE;
		else begin
			case (ms_r)
				MS_IDLE: if (m_start) ms_r <= MS_RUN;
				MS_RUN:  if (m_end) ms_r <= MS_GAP;
				MS_GAP: begin
					if (m_start) ms_r <= MS_RUN;
					else if (tick) ms_r <= MS_IDLE;
				end
				default: ms_r <= MS_IDLE;
			endcase
		end
	end
	assign meas_busy = (ms_r != MS_IDLE);

	// The gap state still counts, so a restart within one period loses nothing.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meas_cnt <= '0;
			meas_ovf <= 1'b0;
		end else begin
			if (meas_clear) meas_cnt <= '0;
			else if (tick && ms_r != MS_IDLE && meas_cnt != MC_MAX) begin
				meas_cnt <= meas_cnt + 24'h1;
			end
			if (tick && ms_r != MS_IDLE && meas_cnt == MC_MAX) meas_ovf <= 1'b1;
			else if (meas_clear) meas_ovf <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access count takes any cycle in range; call count takes range entries.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_cnt       <= '0;
			in_rng_prev_r <= 1'b0;
		end else begin
			if (lnk.cyc && lnk.fetch) in_rng_prev_r <= in_rng;
			if (meas_clear) evt_cnt <= '0;
			else if (meas_en && evt_cnt != EVT_MAX && (
				(meas_mode == MM_ACC && ahit[meas_start_ch]) ||
				(meas_mode == MM_CALL && in_rng && !in_rng_prev_r))) begin
				evt_cnt <= evt_cnt + 16'h1;
			end
		end
	end
endmodule : betu_event_unit

//--- dv/betu_checker.sv
// Concurrent checks on the bus link and the event unit outputs.
`timescale 1ns/1ps
module betu_checker (
	// Clock and reset.
	input wire logic                          clk,
	input wire logic                          resetn,
	// Link.
	input wire logic                          cyc,
	input wire logic                          fetch,
	// Event unit.
	input wire logic                          brk_en,
	input wire logic                          break_req,
	input wire logic                          trc_content_sel,
	input wire logic                          trc_arm,
	input wire logic                          trc_stopped,
	input wire logic                          rec_valid,
	input wire logic [betu_pkg::TS_W-1:0]     rec_stamp,
	input wire logic [betu_pkg::IRQW-1:0]     rec_irq,
	input wire logic                          meas_clear,
	input wire logic [betu_pkg::MC_W-1:0]     meas_cnt,
	input wire logic                          meas_ovf,
	input wire logic                          meas_busy,
	input wire logic [betu_pkg::EC_W-1:0]     evt_cnt,
	input wire betu_pkg::betu_own_e           ch1_owner
);
	import betu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////////
	chk_break_delay: assert property (break_req |-> $past(cyc, 3))
		else $error("break without a bus cycle three clocks earlier");
	chk_break_gate: assert property (!brk_en && !$past(brk_en) && !$past(brk_en, 2)
		&& !$past(brk_en, 3) |-> !break_req)
		else $error("break while breaks are disabled");
	chk_rec_source: assert property (rec_valid |-> $past(cyc))
		else $error("record without a bus cycle");
	chk_stop_quiet: assert property (trc_stopped && !trc_arm |=> !rec_valid)
		else $error("record after trace stop");
	chk_stamp_noirq: assert property (rec_valid && trc_content_sel == TRC_STAMP
		|-> rec_irq == 8'h00)
		else $error("interrupt lines captured in stamp mode");
	chk_irq_lowzero: assert property (rec_valid && trc_content_sel == TRC_IRQ
		|-> rec_stamp[15:0] == 16'h0000)
		else $error("low stamp bits not zero in interrupt mode");
	chk_meas_step: assert property (meas_cnt != $past(meas_cnt) && !$past(meas_clear)
		|-> meas_cnt == $past(meas_cnt) + 24'h000001)
		else $error("measurement counter jumped");
	chk_ovf_sat: assert property ($rose(meas_ovf) |-> meas_cnt == MC_MAX)
		else $error("overflow without saturated counter");
	chk_evt_sat: assert property ($past(evt_cnt) == EVT_MAX && !$past(meas_clear)
		|-> evt_cnt == EVT_MAX)
		else $error("event count wrapped");
	chk_busy_fetch: assert property ($rose(meas_busy) |-> $past(cyc) && $past(fetch))
		else $error("measurement started without a prefetch cycle");
	chk_owner_one: assert property ($onehot(ch1_owner))
		else $error("channel one owner not one-hot");
	cov_break: cover property (break_req);
	cov_irq_rec: cover property (rec_valid && trc_content_sel == TRC_IRQ);
	cov_meas_end: cover property ($fell(meas_busy));
endmodule : betu_checker

//--- dv/bus_event_trace_and_timing_unit_test.sv
// Testbench joining both ends through the link and checking break, trace and timing.
`timescale 1ns/1ps
module bus_event_trace_and_timing_unit_test;
	import betu_pkg::*;
	logic                         clk, resetn, cpu_cyc, cpu_fetch, cpu_run, run_settled;
	logic [AW-1:0]                cpu_addr;
	logic [DW-1:0]                cpu_data;
	logic [1:0]                   cpu_size, res_sel;
	logic [IRQW-1:0]              irq_pins, rec_irq;
	logic [NUM_CH-1:0]            cfg_en, cfg_den, trc_stop_mask;
	logic [NUM_CH-1:0][AW-1:0]    cfg_addr, cfg_amask, cfg_data, cfg_dmask;
	logic [NUM_CH-1:0][1:0]       cfg_dsize;
	logic                         brk_en, prof_active, break_req, trc_arm, trc_content_sel;
	logic                         trc_p2p_en, trc_stopped, rec_valid, meas_en, meas_clear;
	logic                         meas_ovf, meas_busy;
	logic [AW-1:0]                rec_addr, rec_data, rec_stamp;
	logic [PTR_W-1:0]             trace_record_pointer;
	betu_mode_e                   meas_mode;
	logic [3:0]                   meas_start_ch, meas_end_ch;
	logic [MC_W-1:0]              meas_cnt;
	logic [EC_W-1:0]              evt_cnt;
	betu_own_e                    ch1_owner;
	int                           err_count, n_tests, n_rec, lat;

	betu_if betu_if_i ();
	betu_target_tap betu_target_tap_i (.clk(clk), .resetn(resetn), .lnk(betu_if_i.tgt),
		.cpu_cyc(cpu_cyc), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_size(cpu_size),
		.cpu_fetch(cpu_fetch), .cpu_run(cpu_run), .external_interrupt_request_lines(irq_pins),
		.cfg_en(cfg_en), .cfg_addr(cfg_addr), .cfg_amask(cfg_amask), .cfg_den(cfg_den),
		.cfg_data(cfg_data), .cfg_dmask(cfg_dmask), .cfg_dsize(cfg_dsize),
		.run_settled(run_settled));
	betu_event_unit betu_event_unit_i (.clk(clk), .resetn(resetn), .lnk(betu_if_i.emu),
		.brk_en(brk_en), .prof_active(prof_active), .break_req(break_req), .trc_arm(trc_arm),
		.trc_content_sel(trc_content_sel), .trc_p2p_en(trc_p2p_en),
		.trc_stop_mask(trc_stop_mask), .trc_stopped(trc_stopped), .rec_valid(rec_valid),
		.rec_addr(rec_addr), .rec_data(rec_data), .rec_stamp(rec_stamp), .rec_irq(rec_irq),
		.trace_record_pointer(trace_record_pointer), .meas_en(meas_en), .meas_mode(meas_mode),
		.meas_start_ch(meas_start_ch), .meas_end_ch(meas_end_ch), .res_sel(res_sel),
		.meas_clear(meas_clear), .meas_cnt(meas_cnt), .meas_ovf(meas_ovf),
		.meas_busy(meas_busy), .evt_cnt(evt_cnt), .ch1_owner(ch1_owner));
	betu_checker betu_checker_i (.clk(clk), .resetn(resetn), .cyc(betu_if_i.cyc),
		.fetch(betu_if_i.fetch), .brk_en(brk_en), .break_req(break_req),
		.trc_content_sel(trc_content_sel), .trc_arm(trc_arm), .trc_stopped(trc_stopped),
		.rec_valid(rec_valid), .rec_stamp(rec_stamp), .rec_irq(rec_irq),
		.meas_clear(meas_clear), .meas_cnt(meas_cnt), .meas_ovf(meas_ovf),
		.meas_busy(meas_busy), .evt_cnt(evt_cnt), .ch1_owner(ch1_owner));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Records are counted here so a scenario can judge how long tracing went on.
	always @(posedge clk) begin
		if (rec_valid === 1'b1) n_rec <= n_rec + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	task automatic bus(input logic [31:0] a, d, input logic [1:0] s, input logic f);
		@(negedge clk);
		{cpu_cyc, cpu_addr, cpu_data, cpu_size, cpu_fetch} = {1'b1, a, d, s, f};
		@(negedge clk);
		cpu_cyc = 1'b0;
	endtask : bus
	task automatic bus_brk(input logic [31:0] a, d, input logic [1:0] s, output int l);
		l = 0;
		bus(a, d, s, 1'b0);
		for (int k = 1; k <= 8 && l == 0; k++) begin
			@(negedge clk);
			if (break_req === 1'b1) l = k;
		end
	endtask : bus_brk
	task automatic set_ch(input int i, input logic [31:0] a, am, input logic de,
		input logic [31:0] d, dm, input logic [1:0] ds);
		@(negedge clk);
		{cfg_addr[i], cfg_amask[i], cfg_den[i]} = {a, am, de};
		{cfg_data[i], cfg_dmask[i], cfg_dsize[i], cfg_en[i]} = {d, dm, ds, 1'b1};
		wait_n(3);
	endtask : set_ch
	task automatic pulse(ref logic p);
		@(negedge clk);
		p = 1'b1;
		@(negedge clk);
		p = 1'b0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_masks;
		cfg_en = '0;
		set_ch(0, 32'h1000, 32'h000F, 1'b0, 32'h0, 32'h0, SZ_LONG);
		bus_brk(32'h100A, 32'h0, SZ_LONG, lat);
		check_val(lat, BRK_DELAY_CYC);
		bus_brk(32'h1010, 32'h0, SZ_LONG, lat);
		check_val(lat, 0);
		brk_en = 1'b0;
		bus_brk(32'h1000, 32'h0, SZ_LONG, lat);
		check_val(lat, 0);
		brk_en = 1'b1;
	endtask : s_masks
	task automatic sz_case(input logic [1:0] cs, input logic [31:0] ca, cd, cm, ba, bd,
		input logic [1:0] bs, input int ex);
		cfg_en = '0;
		set_ch(0, ca, 32'h0, 1'b1, cd, cm, cs);
		bus_brk(ba, bd, bs, lat);
		check_val(lat, ex);
	endtask : sz_case
	task automatic s_sizes;
		sz_case(SZ_LONG, 32'h2000, 32'h11223344, 0, 32'h2000, 32'h11223344, SZ_LONG, 3);
		sz_case(SZ_LONG, 32'h2000, 32'h11223344, 0, 32'h2000, 32'h11223344, SZ_WORD, 0);
		sz_case(SZ_LONG, 32'h2000, 32'h11223344, 0, 32'h2002, 32'h11223344, SZ_LONG, 3);
		sz_case(SZ_WORD, 32'h2002, 32'h5566, 32'hFFFF0000, 32'h2003, 32'hAAAA5566, SZ_WORD,
			3);
		sz_case(SZ_BYTE, 32'h2001, 32'h770000, 32'hFF00FFFF, 32'h2001, 32'h12773456, SZ_BYTE,
			3);
		sz_case(SZ_BYTE, 32'h2001, 32'h770000, 32'hFF00FFFF, 32'h2000, 32'h770000, SZ_BYTE,
			0);
	endtask : s_sizes
	task automatic s_prof;
		cfg_en = '0;
		set_ch(8, 32'h3300, 32'h0, 1'b0, 32'h0, 32'h0, SZ_LONG);
		prof_active = 1'b1;
		bus_brk(32'h3300, 32'h0, SZ_LONG, lat);
		check_val(lat, 0);
		prof_active = 1'b0;
		bus_brk(32'h3300, 32'h0, SZ_LONG, lat);
		check_val(lat, BRK_DELAY_CYC);
	endtask : s_prof
	task automatic s_trace;
		irq_pins = 8'hA5;
		check_val(run_settled, 1);
		cfg_en = '0;
		set_ch(0, 32'h5000, 32'h0, 1'b0, 32'h0, 32'h0, SZ_LONG);
		trc_stop_mask = 12'h001;
		pulse(trc_arm);
		n_rec = 0;
		for (int k = 0; k < 6; k++) bus(32'h5100 + 4 * k, 32'h0, SZ_LONG, 1'b0);
		bus(32'h5000, 32'h0, SZ_LONG, 1'b0);
		for (int k = 0; k < 6; k++) bus(32'h5200, 32'h0, SZ_LONG, 1'b0);
		wait_n(4);
		check_val(n_rec, 7 + TRACE_TAIL_BUS);
		check_val(trace_record_pointer, 7 + TRACE_TAIL_BUS);
		check_val(trc_stopped, 1);
		check_val(rec_irq, 0);
		trc_stop_mask = '0;
		trc_content_sel = TRC_IRQ;
		pulse(trc_arm);
		bus(32'h5200, 32'h0, SZ_LONG, 1'b0);
		wait_n(2);
		check_val(rec_irq, 32'hA5);
		check_val(rec_stamp[15:0], 0);
		trc_content_sel = TRC_STAMP;
	endtask : s_trace
	task automatic s_meas;
		cfg_en = '0;
		set_ch(1, 32'h3000, 32'h0, 1'b0, 32'h0, 32'h0, SZ_LONG);
		set_ch(2, 32'h3100, 32'h0, 1'b0, 32'h0, 32'h0, SZ_LONG);
		{meas_en, res_sel, meas_start_ch, meas_end_ch} = {1'b1, RES_CLOCK, 4'h1, 4'h2};
		meas_mode = MM_P2P;
		pulse(meas_clear);
		bus(32'h3000, 32'h0, SZ_LONG, 1'b0);
		wait_n(2);
		check_val(meas_busy, 0);
		bus(32'h3000, 32'h0, SZ_LONG, 1'b1);
		for (int k = 0; k < 10; k++) bus(32'h3200, 32'h0, SZ_LONG, 1'b0);
		check_val(meas_busy, 1);
		bus(32'h3100, 32'h0, SZ_LONG, 1'b1);
		wait_n(4);
		check_val(meas_busy, 0);
		check_val(meas_cnt >= 24'h000014 && meas_cnt <= 24'h00001C, 1);
		res_sel = RES_1U6;
		pulse(meas_clear);
		bus(32'h3000, 32'h0, SZ_LONG, 1'b1);
		for (int k = 0; k < 100; k++) bus(32'h3200, 32'h0, SZ_LONG, 1'b0);
		bus(32'h3100, 32'h0, SZ_LONG, 1'b1);
		wait_n(70);
		check_val(meas_busy, 0);
		check_val(meas_cnt >= 24'h000004 && meas_cnt <= 24'h000005, 1);
		res_sel = RES_CLOCK;
		set_ch(1, 32'h4000, 32'hFF, 1'b0, 32'h0, 32'h0, SZ_LONG);
		meas_mode = MM_RANGE;
		bus(32'h4000, 32'h0, SZ_LONG, 1'b1);
		bus(32'h4010, 32'h0, SZ_LONG, 1'b1);
		wait_n(2);
		check_val(meas_busy, 1);
		bus(32'h4100, 32'h0, SZ_LONG, 1'b1);
		wait_n(4);
		check_val(meas_busy, 0);
		meas_mode = MM_ACC;
		pulse(meas_clear);
		for (int k = 0; k < 3; k++) bus(32'h4004, 32'h0, SZ_LONG, 1'b0);
		wait_n(3);
		check_val(evt_cnt, 3);
		meas_mode = MM_CALL;
		pulse(meas_clear);
		bus(32'h4000, 32'h0, SZ_LONG, 1'b1);
		bus(32'h4004, 32'h0, SZ_LONG, 1'b1);
		bus(32'h4100, 32'h0, SZ_LONG, 1'b1);
		bus(32'h4000, 32'h0, SZ_LONG, 1'b1);
		wait_n(3);
		check_val(evt_cnt, 2);
	endtask : s_meas
	task automatic s_owner;
		trc_p2p_en = 1'b1;
		wait_n(3);
		check_val({29'h0, ch1_owner}, {29'h0, OWN_TRACE});
		meas_start_ch = 4'h0;
		wait_n(3);
		check_val({29'h0, ch1_owner}, {29'h0, OWN_TRACE});
		trc_p2p_en = 1'b0;
		wait_n(3);
		check_val({29'h0, ch1_owner}, {29'h0, OWN_MEAS});
		trc_p2p_en = 1'b1;
		wait_n(3);
		check_val({29'h0, ch1_owner}, {29'h0, OWN_MEAS});
	endtask : s_owner
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{err_count, n_tests, n_rec} = '0;
		{resetn, cpu_cyc, cpu_fetch, cpu_run, cpu_addr, cpu_data, cpu_size, irq_pins} = '0;
		{cfg_en, cfg_den, cfg_addr, cfg_amask, cfg_data, cfg_dmask, cfg_dsize} = '0;
		{brk_en, prof_active, trc_arm, trc_content_sel, trc_p2p_en, trc_stop_mask} = '0;
		{meas_en, meas_clear, meas_start_ch, meas_end_ch, res_sel} = '0;
		meas_mode = MM_P2P;
		wait_n(3);
		resetn = 1'b1;
		check_val({29'h0, ch1_owner}, {29'h0, OWN_NONE});
		{cpu_run, brk_en} = 2'b11;
		s_masks;
		s_sizes;
		s_prof;
		s_trace;
		s_meas;
		s_owner;
		give_verdict;
	end
endmodule : bus_event_trace_and_timing_unit_test
